// *** logic/ucp_baud_gen.v ***
// ucp_baud_gen.v: divides the input clock by the programmed divisor into a 16x baud clock
// assumes divisor from a register on the same clock; zero treated as one
`timescale 1ns/10ps
`default_nettype none
module ucp_baud_gen (
  input wire i_clk,
  input wire i_srst,
  input wire [15:0] i_divisor,
  output wire o_tick,
  output reg o_baud_clk_ff
);
  reg [15:0] cnt_ff;
  wire [15:0] div_eff;
  // zero divisor would stall, so treat it like one
  assign div_eff = (i_divisor == 16'h0000) ? 16'h0001 : i_divisor;
  assign o_tick = (cnt_ff >= div_eff - 16'h0001);
  // counter wraps every divisor cycles; each wrap is one sampling tick
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt_ff <= 16'h0000;
      o_baud_clk_ff <= 1'b1;
    end
    else if (o_tick)
    begin
      cnt_ff <= 16'h0000;
      o_baud_clk_ff <= (div_eff == 16'h0001) ? 1'b1 : 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 16'h0001;
      // high for the second half of each period
      if (cnt_ff + 16'h0001 >= (div_eff >> 1))
        o_baud_clk_ff <= 1'b1;
    end
  end
endmodule // ucp_baud_gen
`default_nettype wire

// *** logic/ucp_chan_pins.v ***
// ucp_chan_pins.v: per-channel pin signal logic of a serial controller, APB register slave
// assumes fifo levels and transmitter serial data from logic on the same clock; pins are async
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ucp_consts.vh"
module ucp_chan_pins (
  input wire i_clk,
  input wire i_srst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire [4:0] i_rx_level,
  input wire [4:0] i_rx_trigger,
  input wire i_tx_full,
  input wire i_tx_serial,
  input wire i_tx_active,
  input wire i_rx_pin,
  input wire i_ring_ind_n,
  output reg o_tx_pin_ff,
  output reg o_rx_serial_ff,
  output reg o_multi_function_out_ff,
  output reg o_receive_ready_n_ff,
  output reg o_transmit_ready_n_ff,
  output reg o_rts_n_ff,
  output reg o_dtr_n_ff,
  output wire o_rx_tick,
  output wire o_irq
);
  reg [7:0] mcr_ff;
  reg [7:0] afr_ff;
  reg [15:0] div_ff;
  reg [7:0] ctl_ff;
  reg [1:0] stat_ff;
  reg [1:0] ien_ff;
  reg [1:0] rx_sync_ff;
  reg [1:0] ri_sync_ff;
  reg ri_prev_ff;
  reg [31:0] nxt_prdata;
  reg nxt_mf;
  wire baud_clk;
  wire wr_en;
  wire rd_en;
  wire ri_rise;
  wire rx_has_data;
  wire loop_on;
  wire [1:0] mf_sel;
  wire [1:0] ev_set;
  wire addr_ok;

  // zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign addr_ok = (i_paddr == `UCP_OFF_MCR) | (i_paddr == `UCP_OFF_AFR) | (i_paddr == `UCP_OFF_DIV) |
                   (i_paddr == `UCP_OFF_CTL) | (i_paddr == `UCP_OFF_STAT) | (i_paddr == `UCP_OFF_IEN) |
                   (i_paddr == `UCP_OFF_ICLR) | (i_paddr == `UCP_OFF_PINS);
  assign o_pslverr = i_psel & i_penable & ~addr_ok;
  assign loop_on = mcr_ff[`UCP_MCR_LOOP];
  assign mf_sel = afr_ff[`UCP_AFR_SEL_HI:`UCP_AFR_SEL_LO];

  // baud divider; tick feeds the receiver sampling
  ucp_baud_gen u_baud (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_divisor(div_ff),
    .o_tick(o_rx_tick),
    .o_baud_clk_ff(baud_clk)
  );

  // async pins pass two flops before anyone reads them
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rx_sync_ff <= 2'h3;
      ri_sync_ff <= 2'h3;
      ri_prev_ff <= 1'b1;
    end
    else
    begin
      rx_sync_ff <= {rx_sync_ff[0], i_rx_pin};
      ri_sync_ff <= {ri_sync_ff[0], i_ring_ind_n};
      ri_prev_ff <= ri_sync_ff[1];
    end
  end

  // low-to-high edge on the synced ring pin, i.e. ring ended
  assign ri_rise = ri_sync_ff[1] & ~ri_prev_ff;
  // bit 0 ring event when MSIE is set, bit 1 receive data present, at or above trigger only when DMA1 is set
  assign rx_has_data = (i_rx_level != 5'h00) &&
                       (!ctl_ff[`UCP_CTL_DMA1] || (i_rx_level >= i_rx_trigger));
  assign ev_set = {rx_has_data, ri_rise & ctl_ff[`UCP_CTL_MSIE]};

  // register writes; status set wins over clear
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      mcr_ff <= `UCP_RST_8;
      afr_ff <= `UCP_RST_8;
      div_ff <= `UCP_DIV_RST;
      ctl_ff <= `UCP_RST_8;
      ien_ff <= 2'h0;
      stat_ff <= 2'h0;
    end
    else
    begin
      if (wr_en && i_paddr == `UCP_OFF_MCR)
        mcr_ff <= i_pwdata[7:0];
      if (wr_en && i_paddr == `UCP_OFF_AFR)
        afr_ff <= i_pwdata[7:0];
      if (wr_en && i_paddr == `UCP_OFF_DIV)
        div_ff <= i_pwdata[15:0];
      if (wr_en && i_paddr == `UCP_OFF_CTL)
        ctl_ff <= i_pwdata[7:0];
      if (wr_en && i_paddr == `UCP_OFF_IEN)
        ien_ff <= i_pwdata[1:0];
      if (wr_en && i_paddr == `UCP_OFF_ICLR)
        stat_ff <= (stat_ff & ~i_pwdata[1:0]) | ev_set;
      else
        stat_ff <= stat_ff | ev_set;
    end
  end

  // channel interrupt level
  assign o_irq = |(stat_ff & ien_ff);

  // read mux, registered during setup so data is stable in access
  always @*
  begin
    nxt_prdata = 32'h00000000;
    case (i_paddr)
      `UCP_OFF_MCR: nxt_prdata = {24'h000000, mcr_ff};
      `UCP_OFF_AFR: nxt_prdata = {24'h000000, afr_ff};
      `UCP_OFF_DIV: nxt_prdata = {16'h0000, div_ff};
      `UCP_OFF_CTL: nxt_prdata = {24'h000000, ctl_ff};
      `UCP_OFF_STAT: nxt_prdata = {30'h00000000, stat_ff};
      `UCP_OFF_IEN: nxt_prdata = {30'h00000000, ien_ff};
      `UCP_OFF_PINS: nxt_prdata = {25'h0000000, o_dtr_n_ff, o_rts_n_ff, o_transmit_ready_n_ff,
                                   o_receive_ready_n_ff, o_multi_function_out_ff, o_tx_pin_ff, rx_sync_ff[1]};
      default: nxt_prdata = 32'h00000000;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
      o_prdata <= 32'h00000000;
    else if (rd_en)
      o_prdata <= nxt_prdata;
  end

  // multi-function selector with fixed encoding
  always @*
  begin
    case (mf_sel)
      `UCP_MF_OP: nxt_mf = ~mcr_ff[`UCP_MCR_OP];
      `UCP_MF_BAUD: nxt_mf = baud_clk;
      `UCP_MF_RECEIVE_READY_N: nxt_mf = ~rx_has_data;
      default: nxt_mf = 1'b1; // unused code parks high
    endcase
  end

  // pin outputs; one flop of delay keeps all outputs glitch free
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_multi_function_out_ff <= 1'b1;
      o_receive_ready_n_ff <= 1'b1;
      o_transmit_ready_n_ff <= 1'b1;
      o_rts_n_ff <= 1'b1;
      o_dtr_n_ff <= 1'b1;
      o_tx_pin_ff <= 1'b1;
      o_rx_serial_ff <= 1'b1;
    end
    else
    begin
      o_multi_function_out_ff <= nxt_mf;
      o_receive_ready_n_ff <= ~rx_has_data;
      o_transmit_ready_n_ff <= i_tx_full;
      o_rts_n_ff <= ~mcr_ff[`UCP_MCR_RTS];
      o_dtr_n_ff <= ~mcr_ff[`UCP_MCR_DTR];
      // line idles high unless enabled and shifting, and loopback keeps the pin quiet
      o_tx_pin_ff <= (loop_on || !ctl_ff[`UCP_CTL_TXEN] || !i_tx_active) ? 1'b1 : i_tx_serial;
      // loopback ignores the receive pin and feeds back transmit data
      o_rx_serial_ff <= loop_on ? (i_tx_serial | ~i_tx_active) : rx_sync_ff[1];
    end
  end
endmodule // ucp_chan_pins
`default_nettype wire

// *** logic/ucp_consts.vh ***
// ucp_consts.vh: offsets, field positions, reset values and encodings for the channel pin logic
// assumes inclusion by bare name from the design files
`ifndef UCP_CONSTS_VH
`define UCP_CONSTS_VH
// apb byte offsets
`define UCP_OFF_MCR 12'h000
`define UCP_OFF_AFR 12'h004
`define UCP_OFF_DIV 12'h008
`define UCP_OFF_CTL 12'h00C
`define UCP_OFF_STAT 12'h010
`define UCP_OFF_IEN 12'h014
`define UCP_OFF_ICLR 12'h018
`define UCP_OFF_PINS 12'h01C
// modem control bits
`define UCP_MCR_DTR 0
`define UCP_MCR_RTS 1
`define UCP_MCR_OP 3
`define UCP_MCR_LOOP 4
// multi-function selector field
`define UCP_AFR_SEL_HI 2
`define UCP_AFR_SEL_LO 1
`define UCP_MF_OP 2'h0
`define UCP_MF_BAUD 2'h1
`define UCP_MF_RECEIVE_READY_N 2'h2
// control register bits
`define UCP_CTL_MSIE 0
`define UCP_CTL_TXEN 1
`define UCP_CTL_DMA1 2
// reset values
`define UCP_DIV_RST 16'h0001
`define UCP_RST_8 8'h00
`endif

// *** tb/ucp_chan_pins_bench.sv ***
// ucp_chan_pins_bench.sv: self-checking bench for the channel pin logic
// assumes the modem model on the far side, APB driven from here
`timescale 1ns/10ps
`default_nettype none
module ucp_chan_pins_bench;
  logic i_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_tx_full = 1'b0;
  logic i_tx_serial = 1'b1, i_tx_active = 1'b0, sd = 1'b0, bv = 1'b1, rg = 1'b0, err, p;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic [4:0] i_rx_level = 5'h00, i_rx_trigger = 5'h04;
  logic i_rx_pin, i_ring_ind_n, o_pready, o_pslverr, o_tx_pin_ff, o_rx_serial_ff, o_multi_function_out_ff;
  logic o_receive_ready_n_ff, o_transmit_ready_n_ff, o_rts_n_ff, o_dtr_n_ff, o_rx_tick, o_irq;
  int fail_count = 0, checks = 0, n, k, m;
  wire logic [4:0] pins = {o_multi_function_out_ff, o_receive_ready_n_ff, o_transmit_ready_n_ff, o_rts_n_ff, o_dtr_n_ff};
  // rows: mcr, selector, tx full, rx level, expected pins
  logic [31:0] tv [6] = '{32'h00_0_0_00_1B, 32'h08_0_1_03_07, 32'h03_0_0_00_18,
    32'h01_2_0_01_02, 32'h0A_2_1_00_1D, 32'h08_3_0_00_1B};
  ucp_chan_pins dut_u (.*);
  ucp_modem_model modem_u (.i_clk(i_clk), .i_send(sd), .i_bit(bv), .i_ring(rg), .o_rx_pin(i_rx_pin),
    .o_ring_ind_n(i_ring_ind_n));
  always #50 i_clk = ~i_clk;
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1)
      @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // settle on the falling edge so sampling never races the design
  task automatic w(input int c);
    repeat (c) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // ring burst ends with a rising pin
  task automatic ring;
    @(posedge i_clk);
    rg <= 1'b1;
    repeat (4) @(posedge i_clk);
    rg <= 1'b0;
    w(8);
  endtask
  task automatic conclude;
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog well past the expected run
  initial
  begin
    #500000;
    fail_count++;
    conclude;
  end
  initial
  begin
    w(4);
    chk({o_tx_pin_ff, o_rx_serial_ff, pins, o_irq}, 32'hFE);
    @(posedge i_clk);
    i_srst <= 1'b0;
    bus(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, 12'h00C, 32'h3);
    for (n = 0; n < 6; n++)
    begin
      bus(1'b1, 12'h000, {24'h0, tv[n][31:24]});
      bus(1'b1, 12'h004, {29'h0, tv[n][21:20], 1'b0});
      i_tx_full <= tv[n][16];
      i_rx_level <= tv[n][12:8];
      w(4);
      chk(pins, tv[n][4:0]);
    end
    bus(1'b1, 12'h00C, 32'h7);
    i_rx_level <= 5'h03;
    w(4);
    chk(o_receive_ready_n_ff, 1'b1);
    @(posedge i_clk);
    i_rx_level <= 5'h04;
    w(3);
    chk(o_receive_ready_n_ff, 1'b0);
    bus(1'b1, 12'h008, 32'h4);
    bus(1'b1, 12'h004, 32'h2);
    w(4);
    k = 0;
    m = 0;
    p = o_multi_function_out_ff;
    repeat (40)
    begin
      @(negedge i_clk);
      k += o_rx_tick;
      m += o_multi_function_out_ff & ~p;
      p = o_multi_function_out_ff;
    end
    chk(k, 10);
    chk(m, 10);
    bus(1'b1, 12'h014, 32'h1);
    ring;
    chk(o_irq, 1'b1);
    bus(1'b1, 12'h018, 32'h1);
    w(1);
    chk(o_irq, 1'b0);
    bus(1'b1, 12'h014, 32'h0);
    ring;
    chk(o_irq, 1'b0);
    bus(1'b0, 12'h010, 32'h0);
    chk(rd[0], 1'b1);
    bus(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // serial path: enabled transmitter, then loopback, then disabled
    @(posedge i_clk);
    i_tx_active <= 1'b1;
    i_tx_serial <= 1'b0;
    sd <= 1'b1;
    bv <= 1'b0;
    w(6);
    chk({o_tx_pin_ff, o_rx_serial_ff}, 2'h0);
    bus(1'b1, 12'h000, 32'h10);
    bv <= 1'b1;
    w(6);
    chk({o_tx_pin_ff, o_rx_serial_ff}, 2'h2);
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, 12'h00C, 32'h5);
    w(4);
    chk(o_tx_pin_ff, 1'b1);
    conclude;
  end
endmodule // ucp_chan_pins_bench
`default_nettype wire

// *** tb/ucp_chan_pins_props.sv ***
// ucp_chan_pins_props.sv: port assertions for the channel pin logic
// assumes only the top module's ports, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module ucp_chan_pins_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [4:0] i_rx_level,
  input wire logic [4:0] i_rx_trigger,
  input wire logic i_tx_full,
  input wire logic i_tx_active,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_tx_pin_ff,
  input wire logic o_multi_function_out_ff,
  input wire logic o_receive_ready_n_ff,
  input wire logic o_transmit_ready_n_ff,
  input wire logic o_irq
);
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  reset_level_a: assert property (disable iff (1'b0) i_srst |=> o_tx_pin_ff && o_multi_function_out_ff)
    else $error("reset level");
  reset_irq_a: assert property (disable iff (1'b0) i_srst ##1 i_srst |-> !o_irq)
    else $error("irq in reset");
  tx_ready_a: assert property (1'b1 |=> o_transmit_ready_n_ff == $past(i_tx_full))
    else $error("tx ready");
  tx_idle_a: assert property (!i_tx_active |=> o_tx_pin_ff)
    else $error("tx idle");
  rx_empty_a: assert property (i_rx_level == 5'h00 |=> o_receive_ready_n_ff)
    else $error("rx empty");
  rx_avail_a: assert property (i_rx_trigger != 5'h00 && i_rx_level >= i_rx_trigger |=> !o_receive_ready_n_ff)
    else $error("rx avail");
  bad_addr_a: assert property (i_psel && i_penable && i_paddr > 12'h01C |-> o_pslverr)
    else $error("no slverr");
  read_zero_a: assert property (i_psel && !i_penable && !i_pwrite && i_paddr > 12'h01C |=> o_prdata == 32'h0)
    else $error("unmapped read");
endmodule // ucp_chan_pins_props
bind ucp_chan_pins ucp_chan_pins_props chk_u (.*);
`default_nettype wire

// *** tb/ucp_modem_model.sv ***
// ucp_modem_model.sv: far-end modem driving receive data and ring indicator
// assumes commands from the bench on the bench clock
`timescale 1ns/10ps
`default_nettype none
module ucp_modem_model (
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic i_bit,
  input wire logic i_ring,
  output logic o_rx_pin = 1'b1,
  output logic o_ring_ind_n = 1'b1
);
  // released line reads high through its pull-up
  always @(posedge i_clk)
  begin
    o_rx_pin <= i_send ? i_bit : 1'b1;
    o_ring_ind_n <= ~i_ring;
  end
endmodule // ucp_modem_model
`default_nettype wire
